// *** verilog/flash_burst_pkg.sv ***
// Purpose: shared constants and types for the flash linear burst read path
// Assumes: 32-bit double-word data, 16-bit configuration value
// Notes:   bit positions follow the configuration register layout
package flash_burst_pkg;

  // ---------------------------------------------------------------
  // configuration register layout
  // ---------------------------------------------------------------
  localparam int          CFG_W            = 16;
  localparam int          CFG_READ_MODE    = 15;
  localparam int          CFG_DELAY_LO     = 10;
  localparam int          CFG_DELAY_W      = 4;
  localparam int          CFG_HOLD         = 9;
  localparam int          CFG_IND_TIMING   = 8;
  localparam int          CFG_CLK_EDGE     = 6;
  localparam int          CFG_LEN_LO       = 0;
  localparam int          CFG_LEN_W        = 3;
  localparam logic [15:0] CFG_RESET        = 16'h9CC4;

  // ---------------------------------------------------------------
  // burst lengths and delay mapping
  // ---------------------------------------------------------------
  localparam logic [2:0]  LEN_TWO          = 3'h1;
  localparam logic [2:0]  LEN_FOUR         = 3'h2;
  localparam logic [2:0]  LEN_EIGHT        = 3'h3;
  localparam logic [3:0]  DELAY_MIN_CODE   = 4'h1;
  localparam logic [3:0]  DELAY_MAX_CODE   = 4'h7;
  localparam logic [3:0]  DELAY_CODE_BIAS  = 4'h2;
  localparam int          SECURE_BYTES     = 256;
  localparam int          SECURE_WORDS     = SECURE_BYTES / 4;

  // ---------------------------------------------------------------
  // data path widths
  // ---------------------------------------------------------------
  localparam int          DATA_W           = 32;
  localparam int          ADDR_W           = 20;

  // ---------------------------------------------------------------
  // shared types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_ARRAY,
    SRC_SECURE,
    SRC_CONFIG
  } read_source_e;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              last;
    logic              valid_data;
  } burst_word_s;

endpackage : flash_burst_pkg

// *** verilog/burst_word_buffer.sv ***
// Purpose: two-entry valid/ready buffer for burst words
// Assumes: single clock, synchronous reset copy
// Notes:   in_ready drops only when both entries are held
`timescale 1ns/1ps
module burst_word_buffer #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             flush
);

  initial begin
    if (DEPTH != 2) $error("buffer depth must be 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic             rd_ptr_ff;
  logic             wr_ptr_ff;
  logic [1:0]       count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else if (flush) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)  rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : burst_word_buffer

// *** verilog/flash_linear_burst_read.sv ***
// Purpose: synchronous linear burst read path of a parallel flash
// Assumes: link clock, strobe, selects sampled by clk_sys via two flops
// Notes:   array data arrives from a memory port with fixed one-cycle latency
`timescale 1ns/1ps
module flash_linear_burst_read #(
  parameter int ADDR_W = flash_burst_pkg::ADDR_W,
  parameter int DATA_W = flash_burst_pkg::DATA_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // flash pins (asynchronous to clk_sys)
  input  wire logic              link_clk,
  input  wire logic              chip_select_n,
  input  wire logic              output_gate_n,
  input  wire logic              address_valid_strobe_n,
  input  wire logic [ADDR_W-1:0] addr_pins,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n,
  output logic                   burst_end_indicator_n,
  output logic                   indicator_oe_n,
  // configuration and status
  input  wire logic [15:0]       cfg_wr_data,
  input  wire logic              cfg_wr_en,
  input  wire logic              algorithm_busy,
  input  wire logic              read_config_sel,
  input  wire logic              secure_sector_sel,
  output logic [15:0]            cfg_value,
  output logic                   burst_active,
  // array memory port
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [DATA_W-1:0] mem_data
);

  initial begin
    if (DATA_W != 32) $error("data width must be 32");
    if (ADDR_W < 8)   $error("address width too small");
  end

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rst_sync_ff <= 2'h0;
    else       rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  logic [3:0]        pin_s1_ff;
  logic [3:0]        pin_s2_ff;
  logic [ADDR_W-1:0] addr_s1_ff;
  logic [ADDR_W-1:0] addr_s2_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff  <= 4'hE;
      pin_s2_ff  <= 4'hE;
      addr_s1_ff <= '0;
      addr_s2_ff <= '0;
    end else begin
      pin_s1_ff  <= {address_valid_strobe_n, output_gate_n, chip_select_n, link_clk};
      pin_s2_ff  <= pin_s1_ff;
      addr_s1_ff <= addr_pins;
      addr_s2_ff <= addr_s1_ff;
    end
  end

  logic lclk_s;
  logic cs_n_s;
  logic oe_n_s;
  logic adv_n_s;
  logic lclk_d_ff;
  logic adv_d_ff;
  logic lclk_rise;
  logic adv_rise;
  assign {adv_n_s, oe_n_s, cs_n_s, lclk_s} = pin_s2_ff;
  assign lclk_rise = lclk_s && !lclk_d_ff;
  assign adv_rise  = adv_n_s && !adv_d_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lclk_d_ff <= 1'b0;
      adv_d_ff  <= 1'b1;
    end else begin
      lclk_d_ff <= lclk_s;
      adv_d_ff  <= adv_n_s;
    end
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  logic [15:0] cfg_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= flash_burst_pkg::CFG_RESET;
    end else if (cfg_wr_en && !algorithm_busy) begin
      cfg_ff <= cfg_wr_data;
    end
  end

  logic [2:0] len_code;
  logic [3:0] delay_code;
  logic       burst_mode;
  logic       ind_early;
  assign len_code   = cfg_ff[flash_burst_pkg::CFG_LEN_LO +: flash_burst_pkg::CFG_LEN_W];
  assign delay_code = cfg_ff[flash_burst_pkg::CFG_DELAY_LO +: flash_burst_pkg::CFG_DELAY_W];
  assign ind_early  = cfg_ff[flash_burst_pkg::CFG_IND_TIMING];
  // burst needs read-mode 0, a valid length, hold 0 and rising-edge clocking
  assign burst_mode = !cfg_ff[flash_burst_pkg::CFG_READ_MODE]
                      && (len_code >= flash_burst_pkg::LEN_TWO)
                      && (len_code <= flash_burst_pkg::LEN_EIGHT)
                      && !cfg_ff[flash_burst_pkg::CFG_HOLD]
                      && cfg_ff[flash_burst_pkg::CFG_CLK_EDGE];

  // group mask: 1, 3 or 7 for 2, 4 or 8 words
  function automatic logic [2:0] group_mask(input logic [2:0] code);
    case (code)
      flash_burst_pkg::LEN_TWO:  group_mask = 3'h1;
      flash_burst_pkg::LEN_FOUR: group_mask = 3'h3;
      default:                   group_mask = 3'h7;
    endcase
  endfunction : group_mask

  // wait cycles before first word; codes outside 1..7 clamp to the ends
  function automatic logic [3:0] delay_cycles(input logic [3:0] code);
    if (code < flash_burst_pkg::DELAY_MIN_CODE)
      delay_cycles = flash_burst_pkg::DELAY_MIN_CODE + flash_burst_pkg::DELAY_CODE_BIAS;
    else if (code > flash_burst_pkg::DELAY_MAX_CODE)
      delay_cycles = flash_burst_pkg::DELAY_MAX_CODE + flash_burst_pkg::DELAY_CODE_BIAS;
    else
      delay_cycles = code + flash_burst_pkg::DELAY_CODE_BIAS;
  endfunction : delay_cycles

  // ---------------------------------------------------------------
  // burst sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_DATA,
    ST_INVALID
  } burst_state_e;

  burst_state_e      state_ff;
  logic [3:0]        wait_ff;
  logic [ADDR_W-1:0] start_addr_ff;
  logic [2:0]        offset_ff;
  logic [2:0]        xfer_ff;
  logic              latch_pending_ff;
  logic              start_burst;
  logic [2:0]        mask;
  logic [2:0]        last_xfer;
  logic              adv_clk_low;
  logic              buf_ready;

  assign mask        = group_mask(len_code);
  assign last_xfer   = mask;
  assign adv_clk_low = lclk_rise && !adv_n_s && !latch_pending_ff;
  // latch on first link edge with strobe low, or on strobe rise, whichever first
  assign start_burst = burst_mode && !cs_n_s
                       && (adv_clk_low || (adv_rise && !latch_pending_ff));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_pending_ff <= 1'b0;
    end else if (adv_rise || cs_n_s) begin
      latch_pending_ff <= 1'b0;
    end else if (start_burst) begin
      latch_pending_ff <= 1'b1; // one latch per strobe pulse
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= ST_IDLE;
      wait_ff       <= 4'h0;
      start_addr_ff <= '0;
      offset_ff     <= 3'h0;
      xfer_ff       <= 3'h0;
    end else if (cs_n_s) begin
      state_ff <= ST_IDLE;
    end else if (start_burst) begin
      start_addr_ff <= addr_s2_ff;
      offset_ff     <= addr_s2_ff[2:0] & mask;
      xfer_ff       <= 3'h0;
      wait_ff       <= delay_cycles(delay_code) - 4'h2;
      state_ff      <= ST_DELAY;
    end else if (!adv_n_s && state_ff != ST_IDLE && !latch_pending_ff) begin
      state_ff <= ST_INVALID;
    end else if (lclk_rise && buf_ready) begin
      case (state_ff)
        ST_DELAY: begin
          if (wait_ff == 4'h1) state_ff <= ST_DATA;
          else                 wait_ff  <= wait_ff - 4'h1;
        end
        ST_DATA: begin
          offset_ff <= (offset_ff + 3'h1) & mask;
          xfer_ff   <= (xfer_ff == last_xfer) ? 3'h0 : xfer_ff + 3'h1;
        end
        default: state_ff <= state_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // word fetch into the two-entry buffer
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] word_addr;
  logic              word_ok;
  logic              is_last;
  logic              fetch_ff;
  logic              fetch_last_ff;
  logic              fetch_ok_ff;
  logic              fill_ff;
  logic              fill_last_ff;
  logic              fill_ok_ff;
  assign word_addr = {start_addr_ff[ADDR_W-1:3], (start_addr_ff[2:0] & ~mask) | offset_ff};
  // secure sector: burst words past its 256-byte window read invalid
  assign word_ok   = !(secure_sector_sel
                       && (word_addr >= ADDR_W'(flash_burst_pkg::SECURE_WORDS)));
  assign is_last   = ind_early ? (xfer_ff == last_xfer - 3'h1) : (xfer_ff == last_xfer);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ff      <= 1'b0;
      fetch_last_ff <= 1'b0;
      fetch_ok_ff   <= 1'b0;
      mem_addr      <= '0;
      fill_ff       <= 1'b0;
      fill_last_ff  <= 1'b0;
      fill_ok_ff    <= 1'b0;
    end else begin
      // array data answers one clk_sys after mem_addr
      fill_ff      <= fetch_ff;
      fill_last_ff <= fetch_last_ff;
      fill_ok_ff   <= fetch_ok_ff;
      fetch_ff <= 1'b0;
      if (state_ff == ST_DATA && lclk_rise && buf_ready && !cs_n_s && adv_n_s) begin
        fetch_ff      <= 1'b1;
        fetch_last_ff <= is_last;
        fetch_ok_ff   <= word_ok;
        mem_addr      <= word_addr;
      end else if (!burst_mode || state_ff == ST_IDLE) begin
        mem_addr <= addr_s2_ff; // asynchronous path, no delay applied
      end
    end
  end

  flash_burst_pkg::burst_word_s buf_in;
  flash_burst_pkg::burst_word_s buf_out;
  logic                         buf_valid;
  logic                         present;
  assign buf_in.data       = fill_ok_ff ? mem_data : '0;
  assign buf_in.last       = fill_last_ff;
  assign buf_in.valid_data = fill_ok_ff;
  assign present           = lclk_rise;

  burst_word_buffer #(
    .WIDTH ($bits(flash_burst_pkg::burst_word_s)),
    .DEPTH (2)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (fill_ff),
    .in_ready  (buf_ready),
    .in_data   (buf_in),
    .out_valid (buf_valid),
    .out_ready (present),
    .out_data  (buf_out),
    .flush     (cs_n_s || start_burst)
  );

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic single_read;
  assign single_read = read_config_sel || !burst_mode;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_out              <= '0;
      data_oe_n             <= 1'b1;
      burst_end_indicator_n <= 1'b1;
      indicator_oe_n        <= 1'b1;
      cfg_value             <= flash_burst_pkg::CFG_RESET;
      burst_active          <= 1'b0;
    end else begin
      cfg_value    <= cfg_ff;
      burst_active <= (state_ff != ST_IDLE);
      data_oe_n      <= cs_n_s || oe_n_s;
      indicator_oe_n <= cs_n_s || oe_n_s;
      if (read_config_sel) begin
        data_out <= {16'h0000, cfg_ff}; // held while read_config_sel high
      end else if (single_read) begin
        data_out <= mem_data;
      end else if (present && buf_valid) begin
        data_out <= buf_out.data; // one link clock per word
      end
      if (single_read || cs_n_s) begin
        burst_end_indicator_n <= 1'b1;
      end else if (present) begin
        burst_end_indicator_n <= !(buf_valid && buf_out.last);
      end
    end
  end

endmodule : flash_linear_burst_read

// *** verification/flash_burst_sva.sv ***
// Purpose: port level assertions for the flash burst read path
// Assumes: one clk_sys domain, rstn active low
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module flash_burst_sva #(
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rstn,
  // pins
  input wire logic              chip_select_n,
  input wire logic              output_gate_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_n,
  input wire logic              burst_end_indicator_n,
  input wire logic              indicator_oe_n,
  // configuration and status
  input wire logic [15:0]       cfg_wr_data,
  input wire logic              cfg_wr_en,
  input wire logic              algorithm_busy,
  input wire logic              read_config_sel,
  input wire logic [15:0]       cfg_value,
  input wire logic              burst_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_reset_defaults:
    assert property ($rose(rstn) |-> data_oe_n && indicator_oe_n && cfg_value == flash_burst_pkg::CFG_RESET)
    else $error("outputs not at reset values");
  chk_busy_ignored:
    assert property (cfg_wr_en && algorithm_busy |-> ##2 $stable(cfg_value))
    else $error("configuration changed by a refused write");
  chk_cfg_lands:
    assert property (cfg_wr_en && !algorithm_busy |-> ##2 cfg_value == $past(cfg_wr_data, 2))
    else $error("configuration write not applied");
  chk_async_idle:
    assert property (cfg_value[15] && $past(cfg_value[15]) && !burst_active |=> !burst_active)
    else $error("burst started in asynchronous mode");
  chk_gate_floats:
    assert property (output_gate_n [*8] |-> data_oe_n && indicator_oe_n)
    else $error("outputs driven with gate high");
  chk_select_floats:
    assert property (chip_select_n [*8] |-> data_oe_n && !burst_active)
    else $error("burst kept with select high");
  chk_ind_width:
    assert property ($fell(burst_end_indicator_n) |-> !burst_end_indicator_n [*8] ##[1:40] burst_end_indicator_n)
    else $error("indicator low pulse of wrong length");
  chk_word_hold:
    assert property ($changed(data_out) && !data_oe_n && !read_config_sel |=> $stable(data_out) [*8])
    else $error("burst word not held");
  chk_cfg_read:
    assert property (read_config_sel [*5] ##0 !data_oe_n |-> data_out == {{(DATA_W-16){1'b0}}, cfg_value})
    else $error("configuration read data wrong");
  cover property ($fell(burst_end_indicator_n));
  cover property (cfg_wr_en && algorithm_busy);
  cover property ($rose(burst_active));
endmodule : flash_burst_sva

bind flash_linear_burst_read flash_burst_sva #(.DATA_W(DATA_W)) i_sva (
  .clk_sys(clk_sys), .rstn(rstn), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
  .data_out(data_out), .data_oe_n(data_oe_n), .burst_end_indicator_n(burst_end_indicator_n),
  .indicator_oe_n(indicator_oe_n), .cfg_wr_data(cfg_wr_data), .cfg_wr_en(cfg_wr_en),
  .algorithm_busy(algorithm_busy), .read_config_sel(read_config_sel), .cfg_value(cfg_value),
  .burst_active(burst_active)
);

// *** verification/flash_host_model.sv ***
// Purpose: host side model: link clock source and array contents
// Assumes: link clock runs only while run is high, still low otherwise
// Notes:   each array word is a fixed pattern of its address
`timescale 1ns/1ps
module flash_host_model #(
  parameter int ADDR_W = 20
) (
  // control
  input  wire logic              clk_sys,
  input  wire logic              run,
  // link and array port
  output logic                   link_clk,
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic [31:0]            mem_data
);
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever begin
      if (run) begin
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
      end else begin
        #5;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    mem_data <= {12'hC3A, mem_addr};
  end
endmodule : flash_host_model

// *** verification/tb_flash_linear_burst_read.sv ***
// Purpose: self-checking bench for the flash burst read path
// Assumes: link clock 160 ns, clk_sys 5 ns
// Notes:   burst words are sampled at link falling edges
`timescale 1ns/1ps
module tb_flash_linear_burst_read;
  logic        clk_sys, rstn, link_clk, run, data_oe_n, burst_end_indicator_n, indicator_oe_n;
  logic        chip_select_n, output_gate_n, address_valid_strobe_n, burst_active;
  logic        cfg_wr_en, algorithm_busy, read_config_sel, secure;
  logic [19:0] addr_pins, mem_addr;
  logic [31:0] data_out, mem_data;
  logic [15:0] cfg_wr_data, cfg_value;
  logic [2:0]  len;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  flash_linear_burst_read i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .link_clk(link_clk), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .address_valid_strobe_n(address_valid_strobe_n), .addr_pins(addr_pins),
    .data_out(data_out), .data_oe_n(data_oe_n), .burst_end_indicator_n(burst_end_indicator_n),
    .indicator_oe_n(indicator_oe_n), .cfg_wr_data(cfg_wr_data), .cfg_wr_en(cfg_wr_en),
    .algorithm_busy(algorithm_busy), .read_config_sel(read_config_sel), .secure_sector_sel(secure),
    .cfg_value(cfg_value), .burst_active(burst_active), .mem_addr(mem_addr), .mem_data(mem_data)
  );
  flash_host_model i_host (
    .clk_sys(clk_sys), .run(run), .link_clk(link_clk), .mem_addr(mem_addr), .mem_data(mem_data)
  );

  // ---------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cfg_write(input logic [15:0] v, input logic busy);
    @(posedge clk_sys);
    cfg_wr_data    <= v;
    cfg_wr_en      <= 1'b1;
    algorithm_busy <= busy;
    @(posedge clk_sys);
    cfg_wr_en      <= 1'b0;
    algorithm_busy <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : cfg_write
  task automatic start_burst(input logic [19:0] a);
    @(posedge clk_sys);
    chip_select_n          <= 1'b0;
    output_gate_n          <= 1'b0;
    address_valid_strobe_n <= 1'b0;
    addr_pins              <= a;
    run                    <= 1'b1;
    @(negedge link_clk);
    @(posedge clk_sys);
    address_valid_strobe_n <= 1'b1;
    addr_pins              <= ~a;
  endtask : start_burst
  task automatic end_burst();
    @(posedge clk_sys);
    chip_select_n <= 1'b1;
    output_gate_n <= 1'b1;
    run           <= 1'b0;
    repeat (40) @(posedge clk_sys);
  endtask : end_burst
  task automatic no_burst(input logic [19:0] a);
    start_burst(a);
    repeat (12) @(negedge link_clk);
    check(burst_active, 1'b0);
    check(data_out, {12'hC3A, ~a});
    end_burst();
  endtask : no_burst
  task automatic run_burst(input logic [19:0] a, input logic [3:0] code, input logic [2:0] ln,
                           input logic wc);
    int          n;
    int          first;
    int          idx;
    logic [19:0] wa;
    n     = 1 << ln;
    first = code + 2;
    cfg_write({2'b00, code, 1'b0, wc, 2'b11, 3'h0, ln}, 1'b0);
    start_burst(a);
    for (int k = 1; k <= first + n; k++) begin
      @(negedge link_clk);
      idx = k - first;
      wa  = (a & ~20'(n - 1)) | ((a + 20'(idx)) & 20'(n - 1));
      if (idx >= 0) check(data_out, (secure && wa >= 20'(flash_burst_pkg::SECURE_WORDS)) ? 32'h0 : {12'hC3A, wa});
      if (idx >= 0 && idx < n) check(burst_end_indicator_n, 32'(idx != n - 1 - wc));
    end
    end_burst();
  endtask : run_burst

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn                   = 1'b0;
    run                    = 1'b0;
    chip_select_n          = 1'b1;
    output_gate_n          = 1'b1;
    address_valid_strobe_n = 1'b1;
    addr_pins              = 20'h00000;
    cfg_wr_data            = 16'h0000;
    cfg_wr_en              = 1'b0;
    algorithm_busy         = 1'b0;
    read_config_sel        = 1'b0;
    secure                 = 1'b0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(cfg_value, flash_burst_pkg::CFG_RESET);
    no_burst(20'h00010);
    cfg_write(16'h1DC2, 1'b1);
    check(cfg_value, flash_burst_pkg::CFG_RESET);
    @(posedge clk_sys);
    chip_select_n   <= 1'b0;
    output_gate_n   <= 1'b0;
    read_config_sel <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check(data_out, {16'h0000, flash_burst_pkg::CFG_RESET});
    read_config_sel <= 1'b0;
    end_burst();
    for (int c = 1; c <= 7; c++) begin
      len = 3'(1 + c % 3);
      run_burst(20'(20'h00100 + 3 * c), 4'(c), len, c[1] && len != 3'h1);
    end
    secure <= 1'b1;
    run_burst(20'h0003D, 4'h1, 3'h2, 1'b0);
    run_burst(20'h00045, 4'h2, 3'h1, 1'b0);
    secure <= 1'b0;
    cfg_write(16'h1DC0, 1'b0);
    no_burst(20'h00020);
    cfg_write(16'h9DC3, 1'b0);
    no_burst(20'h00030);
    cfg_write(16'h1DC3, 1'b0);
    start_burst(20'h00040);
    repeat (3) @(negedge link_clk);
    @(posedge clk_sys);
    output_gate_n <= 1'b1;
    repeat (2) @(negedge link_clk);
    check(data_oe_n, 1'b1);
    check(indicator_oe_n, 1'b1);
    check(burst_active, 1'b1);
    @(posedge clk_sys);
    chip_select_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check(data_oe_n, 1'b1);
    check(burst_active, 1'b0);
    end_burst();
    start_burst(20'h00050);
    repeat (11) @(negedge link_clk);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check(data_oe_n, 1'b1);
    check(cfg_value, flash_burst_pkg::CFG_RESET);
    check(burst_active, 1'b0);
    rstn <= 1'b1;
    end_burst();
    complete_run();
  end
endmodule : tb_flash_linear_burst_read
